// ---- phac_top.sv ----
// two-port amplitude, role and negotiation control with wishbone registers
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module phac_top
  import phac_pkg::*;
#(
  parameter int WAIT_CYC = PAGE_WAIT_CYC
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // wishbone slave
  input  wire logic                wb_cyc,
  input  wire logic                wb_stb,
  input  wire logic                wb_we,
  input  wire logic [5:0]          wb_adr,
  input  wire logic [3:0]          wb_sel,
  input  wire logic [31:0]         wb_dat_w,
  output logic [31:0]              wb_dat_r,
  output logic                     wb_ack,
  // straps
  input  wire logic                port1_high_amplitude_strap,
  input  wire logic                port2_high_amplitude_strap,
  // link side, index 0 is port 1
  input  wire logic [1:0]          link_up,
  input  wire logic [1:0]          rx_page_valid,
  input  wire phac_page_s [1:0]    rx_page,
  output logic [1:0]               tx_page_valid,
  output phac_page_s [1:0]         tx_page,
  // resolved operation
  output logic [1:0]               tx_amplitude_select,
  output logic [1:0]               role_prefer_master_bit,
  output logic [1:0]               negotiation_done_flag
);
  logic [1:0]   an_en, next_an_en;
  logic [1:0]   force_ms, next_force_ms;
  logic [1:0]   adv_high_level_ability, next_adv_abl;
  logic [1:0]   adv_high_level_request, next_adv_req;
  logic [1:0]   next_mst, next_txhi;
  logic [1:0]   strap_q, next_strap_q;
  logic         strap_taken, next_strap_taken;
  logic [1:0]   restart_pulse, next_restart;
  logic [1:0]   done_prev, next_done_prev;
  logic         next_ack;
  logic [31:0]  next_dat_r;
  phac_page_s   local_page [2];
  phac_page_s   partner [2];
  phac_result_s result [2];
  logic [1:0]   high_level_ability_status;
  logic [3:0]   dec;
  logic         wr_commit;
  logic [7:0]   wbyte;

  // {hit, port, reg index}; reg 0 ctrl, 1 adv, 2 stat
  function automatic logic [3:0] decode(logic [5:0] a);
    logic [3:0] d;
    logic [5:0] o;
    d = 4'h0;
    o = (a >= PORT_STRIDE) ? a - PORT_STRIDE : a;
    if (a >= (PORT_STRIDE << 1)) begin
      d = 4'h0;
    end else if (o == REG_CTRL) begin
      d = {1'b1, a >= PORT_STRIDE, 2'd0};
    end else if (o == REG_ADV) begin
      d = {1'b1, a >= PORT_STRIDE, 2'd1};
    end else if (o == REG_STAT) begin
      d = {1'b1, a >= PORT_STRIDE, 2'd2};
    end
    return d;
  endfunction : decode

  assign high_level_ability_status = ~strap_q;

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign local_page[p] = '{ability: adv_high_level_ability[p], request: adv_high_level_request[p],
                             prefer_master: role_prefer_master_bit[p], force_ms: force_ms[p], seed: 5'h00};
    phac_an_port #(
      .WAIT_CYC (WAIT_CYC)
    ) u_an (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .an_enable  (an_en[p]),
      .restart    (restart_pulse[p]),
      .link_up    (link_up[p]),
      .local_page (local_page[p]),
      .rx_valid   (rx_page_valid[p]),
      .rx_page    (rx_page[p]),
      .tx_valid   (tx_page_valid[p]),
      .tx_page    (tx_page[p]),
      .partner    (partner[p]),
      .result     (result[p])
    );
    assign negotiation_done_flag[p] = result[p].done;
  end

  // configuration registers
  always_comb begin
    next_an_en       = an_en;
    next_force_ms    = force_ms;
    next_adv_abl     = adv_high_level_ability;
    next_adv_req     = adv_high_level_request;
    next_mst         = role_prefer_master_bit;
    next_txhi        = tx_amplitude_select;
    next_strap_q     = strap_q;
    next_strap_taken = 1'b1;
    next_restart     = 2'b00;
    next_done_prev   = {result[1].done, result[0].done};
    dec              = decode(wb_adr);
    wr_commit        = wb_cyc & wb_stb & wb_we & wb_ack & wb_sel[0] & dec[3];
    wbyte            = wb_dat_w[7:0];
    if (!strap_taken) begin
      // caught once so later strap wiggles cannot move the defaults
      next_strap_q = {port2_high_amplitude_strap, port1_high_amplitude_strap};
      next_adv_abl = ~next_strap_q;
      next_adv_req = ~next_strap_q;
    end
    for (int p = 0; p < 2; p++) begin
      if (an_en[p] && result[p].done && !done_prev[p]) begin
        next_mst[p]  = result[p].master;
        next_txhi[p] = result[p].hi_level & ~strap_q[p];
      end
      if (wr_commit && dec[2] == p[0]) begin
        if (dec[1:0] == 2'd0) begin
          next_an_en[p]    = wbyte[CTRL_AN_EN];
          next_force_ms[p] = wbyte[CTRL_FORCE];
          next_restart[p]  = wbyte[CTRL_RESTART];
          if (!an_en[p]) begin
            next_mst[p]  = wbyte[CTRL_MST];
            next_txhi[p] = wbyte[CTRL_TXHI] & ~strap_q[p];
          end
        end else if (dec[1:0] == 2'd1) begin
          // 1.0 V-only ports cannot advertise the high level
          next_adv_abl[p] = wbyte[ADV_ABL] & ~strap_q[p];
          next_adv_req[p] = wbyte[ADV_REQ] & ~strap_q[p];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      an_en                  <= AN_EN_RST;
      force_ms               <= 2'h0;
      adv_high_level_ability <= 2'h0;
      adv_high_level_request <= 2'h0;
      role_prefer_master_bit <= MST_RST;
      tx_amplitude_select    <= 2'h0;
      strap_q                <= 2'h0;
      strap_taken            <= 1'b0;
      restart_pulse          <= 2'h0;
      done_prev              <= 2'h0;
    end else begin
      an_en                  <= next_an_en;
      force_ms               <= next_force_ms;
      adv_high_level_ability <= next_adv_abl;
      adv_high_level_request <= next_adv_req;
      role_prefer_master_bit <= next_mst;
      tx_amplitude_select    <= next_txhi;
      strap_q                <= next_strap_q;
      strap_taken            <= next_strap_taken;
      restart_pulse          <= next_restart;
      done_prev              <= next_done_prev;
    end
  end

  // bus answer: ack one cycle after the request, read data with it
  always_comb begin
    next_ack   = wb_cyc & wb_stb & ~wb_ack;
    next_dat_r = 32'h0000_0000;
    if (next_ack && !wb_we && dec[3]) begin
      if (dec[1:0] == 2'd0) begin
        next_dat_r[CTRL_AN_EN] = an_en[dec[2]];
        next_dat_r[CTRL_MST]   = role_prefer_master_bit[dec[2]];
        next_dat_r[CTRL_TXHI]  = tx_amplitude_select[dec[2]];
        next_dat_r[CTRL_FORCE] = force_ms[dec[2]];
      end else if (dec[1:0] == 2'd1) begin
        next_dat_r[ADV_ABL] = adv_high_level_ability[dec[2]];
        next_dat_r[ADV_REQ] = adv_high_level_request[dec[2]];
      end else begin
        next_dat_r[ST_ABLE]   = high_level_ability_status[dec[2]];
        next_dat_r[ST_DONE]   = result[dec[2]].done;
        next_dat_r[ST_LP_ABL] = partner[dec[2]].ability;
        next_dat_r[ST_LP_REQ] = partner[dec[2]].request;
        next_dat_r[ST_LINK]   = link_up[dec[2]];
        next_dat_r[ST_MASTER] = role_prefer_master_bit[dec[2]];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end else begin
      wb_ack   <= next_ack;
      wb_dat_r <= next_dat_r;
    end
  end

  property p_strap_hold;
    @(posedge clk_sys) disable iff (rst)
    strap_taken |=> $stable(strap_q) && strap_taken;
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap copy moved");

  property p_adv_default;
    @(posedge clk_sys) disable iff (rst)
    $rose(strap_taken) |-> adv_high_level_ability == ~strap_q && adv_high_level_request == ~strap_q;
  endproperty
  a_adv_default: assert property (p_adv_default) else $error("advert default not from strap");

  property p_low_only;
    @(posedge clk_sys) disable iff (rst)
    strap_taken |-> (strap_q & (tx_amplitude_select | adv_high_level_ability)) == 2'h0;
  endproperty
  a_low_only: assert property (p_low_only) else $error("1.0 V-only port uses high level");

  property p_status_ro;
    @(posedge clk_sys) disable iff (rst)
    (wb_ack && !wb_we && wb_adr == REG_STAT) |-> wb_dat_r[ST_ABLE] == ~strap_q[0];
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("ability status not strap");

  property p_reset_defaults;
    @(posedge clk_sys)
    rst ##1 !rst |-> role_prefer_master_bit == MST_RST && an_en == AN_EN_RST;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset role or enable");

  property p_role_locked;
    @(posedge clk_sys) disable iff (rst)
    (wr_commit && wb_adr == REG_CTRL && an_en[0] && !(result[0].done && !done_prev[0]))
      |=> role_prefer_master_bit[0] == $past(role_prefer_master_bit[0]);
  endproperty
  a_role_locked: assert property (p_role_locked) else $error("role written while negotiating");

  property p_level_follow;
    @(posedge clk_sys) disable iff (rst)
    (an_en[0] && result[0].done && !done_prev[0])
      |=> tx_amplitude_select[0] == $past(result[0].hi_level) && role_prefer_master_bit[0] == $past(result[0].master);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("negotiated result not applied");

  property p_restart;
    @(posedge clk_sys) disable iff (rst)
    (restart_pulse[1] && an_en[1]) |-> ##2 tx_page_valid[1];
  endproperty
  a_restart: assert property (p_restart) else $error("restart sent no page");

  property p_ack_one;
    @(posedge clk_sys) disable iff (rst)
    wb_ack |=> !wb_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  c_write_ctrl: cover property (@(posedge clk_sys) disable iff (rst) wr_commit && wb_adr == REG_CTRL);
  c_hi_level: cover property (@(posedge clk_sys) disable iff (rst) tx_amplitude_select == 2'h1);
  c_restart: cover property (@(posedge clk_sys) disable iff (rst) restart_pulse[0] ##2 tx_page_valid[0]);
  c_done_both: cover property (@(posedge clk_sys) disable iff (rst) negotiation_done_flag == 2'h3);
endmodule : phac_top
`default_nettype wire

// ---- phac_pkg.sv ----
// shared constants, carriers and resolution helpers for the port negotiation block
package phac_pkg;
  // timing
  localparam int CLK_MHZ       = 200;
  localparam int PAGE_WAIT_US  = 10;
  localparam int PAGE_WAIT_CYC = PAGE_WAIT_US * CLK_MHZ;
  // register byte offsets; port 2 sits one stride above port 1
  localparam logic [5:0] REG_CTRL    = 6'h00;
  localparam logic [5:0] REG_ADV     = 6'h04;
  localparam logic [5:0] REG_STAT    = 6'h08;
  localparam logic [5:0] PORT_STRIDE = 6'h10;
  // control fields
  localparam int CTRL_AN_EN   = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_MST     = 2;
  localparam int CTRL_TXHI    = 3;
  localparam int CTRL_FORCE   = 4;
  // advertisement fields
  localparam int ADV_ABL = 0;
  localparam int ADV_REQ = 1;
  // status fields
  localparam int ST_ABLE   = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_LP_ABL = 2;
  localparam int ST_LP_REQ = 3;
  localparam int ST_LINK   = 4;
  localparam int ST_MASTER = 5;
  // reset values, bit 0 is port 1
  localparam logic [1:0] AN_EN_RST = 2'h3;
  localparam logic [1:0] MST_RST   = 2'h1;
  localparam logic [4:0] SEED_RST  = 5'h01;

  typedef struct packed {
    logic       ability;
    logic       request;
    logic       prefer_master;
    logic       force_ms;
    logic [4:0] seed;
  } phac_page_s;

  typedef struct packed {
    logic done;
    logic hi_level;
    logic master;
  } phac_result_s;

  typedef enum logic [1:0] {
    AN_IDLE = 2'b00,
    AN_SEND = 2'b01,
    AN_WAIT = 2'b10,
    AN_DONE = 2'b11
  } phac_an_state_e;

  function automatic logic phac_resolve_hi(phac_page_s l, phac_page_s p);
    return l.ability & p.ability & (l.request | p.request);
  endfunction : phac_resolve_hi

  // returns {conflict, local_is_master}
  function automatic logic [1:0] phac_resolve_ms(phac_page_s l, phac_page_s p);
    logic [1:0] r;
    r = 2'b00;
    if (l.force_ms && p.force_ms) begin
      r = {l.prefer_master == p.prefer_master, l.prefer_master};
    end else if (l.force_ms) begin
      r = {1'b0, l.prefer_master};
    end else if (p.force_ms) begin
      r = {1'b0, ~p.prefer_master};
    end else if (l.prefer_master != p.prefer_master) begin
      r = {1'b0, l.prefer_master};
    end else begin
      r = {l.seed == p.seed, l.seed > p.seed};
    end
    return r;
  endfunction : phac_resolve_ms
endpackage : phac_pkg

// ---- phac_an_port.sv ----
// one port's negotiation engine: page send, partner capture, arbitration
`timescale 1ns/10ps
`default_nettype none
module phac_an_port
  import phac_pkg::*;
#(
  parameter int WAIT_CYC = PAGE_WAIT_CYC
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // control
  input  wire logic         an_enable,
  input  wire logic         restart,
  input  wire logic         link_up,
  input  wire phac_page_s   local_page,
  // partner page in
  input  wire logic         rx_valid,
  input  wire phac_page_s   rx_page,
  // own page out and results
  output logic              tx_valid,
  output phac_page_s        tx_page,
  output phac_page_s        partner,
  output phac_result_s      result
);
  localparam int TW = $clog2(WAIT_CYC + 1);

  phac_an_state_e state, next_state;
  logic [TW-1:0]  timer, next_timer;
  logic [4:0]     lfsr, next_lfsr;
  logic           link_was, next_link_was;
  logic           next_tx_valid;
  phac_page_s     next_tx_page, next_partner;
  phac_result_s   next_result;
  logic [1:0]     ms;
  logic           drop;

  always_comb begin
    next_state    = state;
    next_timer    = timer;
    next_lfsr     = {lfsr[3:0], lfsr[4] ^ lfsr[2]};
    next_link_was = link_up;
    next_tx_valid = 1'b0;
    next_tx_page  = tx_page;
    next_partner  = partner;
    next_result   = result;
    ms            = phac_resolve_ms(tx_page, rx_page);
    drop          = link_was & ~link_up;
    if (!an_enable) begin
      next_state       = AN_IDLE;
      next_result.done = 1'b0;
    end else if (restart || (state == AN_DONE && drop)) begin
      next_state       = AN_SEND;
      next_result.done = 1'b0;
    end else begin
      case (state)
        AN_IDLE: next_state = AN_SEND;
        AN_SEND: begin
          next_tx_valid     = 1'b1;
          next_tx_page      = local_page;
          next_tx_page.seed = lfsr;
          next_timer        = TW'(WAIT_CYC - 1);
          next_result.done  = 1'b0;
          next_state        = AN_WAIT;
        end
        AN_WAIT: begin
          if (rx_valid) begin
            next_partner = rx_page;
            // equal seeds or clashing forced roles: retry with a fresh seed
            if (ms[1]) begin
              next_state = AN_SEND;
            end else begin
              next_result = '{done: 1'b1, hi_level: phac_resolve_hi(tx_page, rx_page), master: ms[0]};
              next_state  = AN_DONE;
            end
          end else if (timer == '0) begin
            next_state = AN_SEND;
          end else begin
            next_timer = timer - TW'(1);
          end
        end
        default: next_state = AN_DONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state    <= AN_IDLE;
      timer    <= '0;
      lfsr     <= SEED_RST;
      link_was <= 1'b0;
      tx_valid <= 1'b0;
      tx_page  <= '0;
      partner  <= '0;
      result   <= '0;
    end else begin
      state    <= next_state;
      timer    <= next_timer;
      lfsr     <= next_lfsr;
      link_was <= next_link_was;
      tx_valid <= next_tx_valid;
      tx_page  <= next_tx_page;
      partner  <= next_partner;
      result   <= next_result;
    end
  end

  property p_drop_restart;
    @(posedge clk_sys) disable iff (rst)
    (an_enable && !restart && state == AN_DONE && link_was && !link_up) |=> state == AN_SEND ##1 tx_valid;
  endproperty
  a_drop_restart: assert property (p_drop_restart) else $error("no renegotiation after link drop");

  property p_level;
    @(posedge clk_sys) disable iff (rst)
    $rose(result.done) |->
      result.hi_level == (tx_page.ability && partner.ability && (tx_page.request || partner.request));
  endproperty
  a_level: assert property (p_level) else $error("resolved level wrong");

  property p_one_master;
    @(posedge clk_sys) disable iff (rst)
    $rose(result.done) |-> phac_resolve_ms(tx_page, partner) == {1'b0, result.master};
  endproperty
  a_one_master: assert property (p_one_master) else $error("role resolved with conflict");

  c_done: cover property (@(posedge clk_sys) disable iff (rst) $rose(result.done) && result.hi_level);
endmodule : phac_an_port
`default_nettype wire

// ---- phac_lp_model.sv ----
// behavioural link partner: answers each page the port sends with a configured page
`timescale 1ns/10ps
`default_nettype none
module phac_lp_model
  import phac_pkg::*;
#(
  parameter int DLY = 4
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // page from the local port
  input  wire logic       tx_valid,
  // page this partner advertises
  input  wire phac_page_s page_cfg,
  // page back to the local port
  output logic            rx_valid,
  output phac_page_s      rx_page
);
  logic [4:0] cnt;
  logic       busy;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy     <= 1'b0;
      cnt      <= 5'h00;
      rx_valid <= 1'b0;
      rx_page  <= '0;
    end else begin
      rx_valid <= 1'b0;
      // idle lines toggle so a stale page can never look valid
      rx_page  <= phac_page_s'(~rx_page);
      if (tx_valid) begin
        busy <= 1'b1;
        cnt  <= 5'(DLY);
      end else if (busy) begin
        if (cnt == 5'h00) begin
          busy     <= 1'b0;
          rx_valid <= 1'b1;
          rx_page  <= page_cfg;
        end else begin
          cnt <= cnt - 5'h01;
        end
      end
    end
  end
endmodule : phac_lp_model
`default_nettype wire

// ---- phac_top_tb_top.sv ----
// bench for the two-port amplitude, role and negotiation control block
`timescale 1ns/10ps
`default_nettype none
module phac_top_tb_top
  import phac_pkg::*;
;
  logic            clk_sys = 1'b0;
  logic            rst = 1'b1;
  logic            wb_cyc = 1'b0;
  logic            wb_stb = 1'b0;
  logic            wb_we = 1'b0;
  logic [5:0]      wb_adr = 6'h00;
  logic [3:0]      wb_sel = 4'h0;
  logic [31:0]     wb_dat_w = 32'h0;
  logic [31:0]     wb_dat_r;
  logic            wb_ack;
  logic            port1_high_amplitude_strap = 1'b0;
  logic            port2_high_amplitude_strap = 1'b1;
  logic [1:0]      link_up = 2'h3;
  phac_page_s      cfg0 = '{1'b1, 1'b0, 1'b0, 1'b0, 5'h03};
  phac_page_s      cfg1 = '{1'b1, 1'b1, 1'b1, 1'b0, 5'h05};
  phac_page_s      rxp0;
  phac_page_s      rxp1;
  logic [1:0]      rxv;
  logic [1:0]      txv;
  phac_page_s [1:0] txp;
  logic [1:0]      amp;
  logic [1:0]      role;
  logic [1:0]      done;
  logic [31:0]     rd;
  int              fail_count = 0;
  int              check_count = 0;

  always #2.5 clk_sys = ~clk_sys;

  phac_top #(.WAIT_CYC(20)) phac_top_inst (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .port1_high_amplitude_strap(port1_high_amplitude_strap),
    .port2_high_amplitude_strap(port2_high_amplitude_strap), .link_up(link_up),
    .rx_page_valid(rxv), .rx_page({rxp1, rxp0}), .tx_page_valid(txv), .tx_page(txp),
    .tx_amplitude_select(amp), .role_prefer_master_bit(role), .negotiation_done_flag(done));
  // port 1 partner answers fast, port 2 partner slowly
  phac_lp_model #(.DLY(4)) phac_lp_model_inst0 (.clk_sys(clk_sys), .rst(rst), .tx_valid(txv[0]),
    .page_cfg(cfg0), .rx_valid(rxv[0]), .rx_page(rxp0));
  phac_lp_model #(.DLY(12)) phac_lp_model_inst1 (.clk_sys(clk_sys), .rst(rst), .tx_valid(txv[1]),
    .page_cfg(cfg1), .rx_valid(rxv[1]), .rx_page(rxp1));

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= d;
    wb_sel   <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("BAD t=%0t bus answer missing", $time);
      summarize();
    end
  endtask : wb

  task automatic rchk(input logic [5:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    chk(rd & mask, exp, what);
  endtask : rchk

  // waits for a port's done flag to reach a level, then lets results settle
  task automatic wait_done(input int p, input logic v);
    int n;
    n = 0;
    while (done[p] !== v && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (2) @(posedge clk_sys);
    if (n >= 400) begin
      fail_count++;
      $display("BAD t=%0t done flag stuck on port %0d", $time, p + 1);
      summarize();
    end
  endtask : wait_done

  initial begin
    logic la, lr, pa, pr;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(role, 32'h1, "role after reset");
    chk(done, 32'h0, "done after reset");
    rchk(REG_CTRL, 32'h1f, 32'h05, "p1 ctrl");
    rchk(REG_CTRL + PORT_STRIDE, 32'h1f, 32'h01, "p2 ctrl");
    rchk(REG_ADV, 32'h3, 32'h3, "p1 adv");
    rchk(REG_ADV + PORT_STRIDE, 32'h3, 32'h0, "p2 adv");
    port1_high_amplitude_strap <= 1'b1;
    port2_high_amplitude_strap <= 1'b0;
    wait_done(0, 1'b1);
    wait_done(1, 1'b1);
    chk(amp, 32'h1, "resolved levels");
    chk(role, 32'h1, "resolved roles");
    chk({txp[0].ability, txp[0].request, txp[0].prefer_master}, 32'h7, "p1 sent page");
    rchk(REG_STAT, 32'h3f, 32'h37, "p1 stat");
    rchk(REG_STAT + PORT_STRIDE, 32'h3f, 32'h1e, "p2 stat");
    wb(1'b1, REG_STAT, 32'h0);
    rchk(REG_STAT, 32'h3f, 32'h37, "p1 stat after write");
    rchk(6'h20, 32'hffffffff, 32'h0, "unmapped read");
    for (int i = 0; i < 16; i++) begin
      {pr, pa, lr, la} = 4'(i);
      wb(1'b1, REG_ADV, {30'h0, lr, la});
      cfg0.ability <= pa;
      cfg0.request <= pr;
      wb(1'b1, REG_CTRL, 32'h03);
      wait_done(0, 1'b0);
      wait_done(0, 1'b1);
      chk(amp[0], la & pa & (lr | pr), "level table");
    end
    wb(1'b1, REG_CTRL + PORT_STRIDE, 32'h03);
    wait_done(1, 1'b0);
    wait_done(1, 1'b1);
    chk({role[1], amp[1]}, 32'h0, "p2 renegotiated");
    @(posedge clk_sys);
    link_up[0] <= 1'b0;
    wait_done(0, 1'b0);
    chk(done[0], 32'h0, "done on link drop");
    link_up[0] <= 1'b1;
    wait_done(0, 1'b1);
    chk(done[0], 32'h1, "renegotiated");
    // role and level writes only land once negotiation is already off
    wb(1'b1, REG_CTRL, 32'h00);
    @(posedge clk_sys);
    chk({role[0], amp[0]}, 32'h3, "role held while negotiating");
    wb(1'b1, REG_CTRL, 32'h04);
    @(posedge clk_sys);
    chk({role[0], amp[0]}, 32'h2, "manual master");
    wb(1'b1, REG_CTRL, 32'h08);
    repeat (2) @(posedge clk_sys);
    chk({role[0], amp[0]}, 32'h1, "manual high level");
    wb(1'b1, REG_CTRL, 32'h04);
    wb(1'b1, REG_CTRL + PORT_STRIDE, 32'h00);
    wb(1'b1, REG_CTRL + PORT_STRIDE, 32'h0c);
    repeat (2) @(posedge clk_sys);
    chk({role, amp}, 32'hc, "manual roles");
    summarize();
  end
endmodule : phac_top_tb_top
`default_nettype wire
